// ---- rtl/alc_acc_load.sv ----
/*
 * Decode and execute slice for the single-cycle loads of the accumulator
 * from control registers and the stack pointer.
 * Assumes the source registers are on CLK and the core writes the
 * accumulator from ACC_WDATA when ACC_WE is high; carry and skip logic
 * lives in the core and is told to stay put.
 * Each opcode has its own comparator, so the decode is a flat OR of
 * nine full-width matches with no priority between them.
 * Source values are sampled in the same cycle as the opcode; the core
 * must not change them in that cycle from another path.
 * Limitation: at most one write per cycle; back-to-back loads are fine.
 */
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Pull-up register 3 opcode loads accumulator
// - Stack pointer to low bits, bit three zero
// - First interrupt control opcode loads accumulator
// - Second interrupt control opcode loads accumulator
// - First timer control opcode loads accumulator
// - Second timer control load, carry unchanged, no skip
// - Third timer control load, single cycle
// - Fourth timer control opcode loads accumulator
// - Fifth timer control opcode loads accumulator
module alc_acc_load (
    input  wire logic                        CLK,
    input  wire logic                        RST,
    input  wire logic [alc_pkg::INSTR_W-1:0] INSTR,
    input  wire logic                        INSTR_VALID,
    input  wire logic [alc_pkg::DATA_W-1:0]  PULLUP_CTRL_REG_3,
    input  wire logic [alc_pkg::SP_W-1:0]    STACK_POINTER,
    input  wire logic [alc_pkg::DATA_W-1:0]  IRQ_CTRL_FIRST,
    input  wire logic [alc_pkg::DATA_W-1:0]  IRQ_CTRL_SECOND,
    input  wire logic [alc_pkg::DATA_W-1:0]  TIMER_CTRL_FIRST,
    input  wire logic [alc_pkg::DATA_W-1:0]  TIMER_CTRL_SECOND,
    input  wire logic [alc_pkg::DATA_W-1:0]  TIMER_CTRL_THIRD,
    input  wire logic [alc_pkg::DATA_W-1:0]  TIMER_CTRL_FOURTH,
    input  wire logic [alc_pkg::DATA_W-1:0]  TIMER_CTRL_FIFTH,
    output logic                             DECODE_HIT,
    output logic                             ACC_WE,
    output logic [alc_pkg::DATA_W-1:0]       ACC_WDATA,
    output logic [alc_pkg::NUM_SRC-1:0]      SRC_SEL,
    output logic                             CARRY_FLAG_WE,
    output logic                             SKIP_REQ
);

    logic [alc_pkg::NUM_SRC-1:0]                      hit;
    logic [alc_pkg::NUM_SRC-1:0][alc_pkg::DATA_W-1:0] src;
    logic [alc_pkg::NUM_SRC-1:0]                      sel_nxt;
    logic [alc_pkg::NUM_SRC-1:0]                      sel_r;
    logic                                             we_nxt;
    logic                                             we_r;
    logic [alc_pkg::DATA_W-1:0]                       wdata_nxt;
    logic [alc_pkg::DATA_W-1:0]                       wdata_r;

    // One comparator per opcode; a shared decoder would hide which pattern slipped
    // Pull-up register 3 load
    alc_op_match #(
        .OPCODE (alc_pkg::OP_LOAD_ACC_PULLUP_CTRL_3)
    ) u_match_pullup3 (
        .instr  (INSTR),
        .valid  (INSTR_VALID),
        .hit    (hit[alc_pkg::SRC_PULLUP3])
    );

    // Stack pointer load
    alc_op_match #(
        .OPCODE (alc_pkg::OP_LOAD_ACC_STACK_POINTER)
    ) u_match_stack (
        .instr  (INSTR),
        .valid  (INSTR_VALID),
        .hit    (hit[alc_pkg::SRC_STACK])
    );

    // First interrupt control load
    alc_op_match #(
        .OPCODE (alc_pkg::OP_LOAD_ACC_IRQ_CTRL_FIRST)
    ) u_match_irq1 (
        .instr  (INSTR),
        .valid  (INSTR_VALID),
        .hit    (hit[alc_pkg::SRC_IRQ1])
    );

    // Second interrupt control load
    alc_op_match #(
        .OPCODE (alc_pkg::OP_LOAD_ACC_IRQ_CTRL_SECOND)
    ) u_match_irq2 (
        .instr  (INSTR),
        .valid  (INSTR_VALID),
        .hit    (hit[alc_pkg::SRC_IRQ2])
    );

    // First timer control load
    alc_op_match #(
        .OPCODE (alc_pkg::OP_LOAD_ACC_TIMER_CTRL_1)
    ) u_match_timer1 (
        .instr  (INSTR),
        .valid  (INSTR_VALID),
        .hit    (hit[alc_pkg::SRC_TIMER1])
    );

    // Second timer control load
    alc_op_match #(
        .OPCODE (alc_pkg::OP_LOAD_ACC_TIMER_CTRL_2)
    ) u_match_timer2 (
        .instr  (INSTR),
        .valid  (INSTR_VALID),
        .hit    (hit[alc_pkg::SRC_TIMER2])
    );

    // Third timer control load
    alc_op_match #(
        .OPCODE (alc_pkg::OP_LOAD_ACC_TIMER_CTRL_3)
    ) u_match_timer3 (
        .instr  (INSTR),
        .valid  (INSTR_VALID),
        .hit    (hit[alc_pkg::SRC_TIMER3])
    );

    // Fourth timer control load
    alc_op_match #(
        .OPCODE (alc_pkg::OP_LOAD_ACC_TIMER_CTRL_4)
    ) u_match_timer4 (
        .instr  (INSTR),
        .valid  (INSTR_VALID),
        .hit    (hit[alc_pkg::SRC_TIMER4])
    );

    // Fifth timer control load
    alc_op_match #(
        .OPCODE (alc_pkg::OP_LOAD_ACC_TIMER_CTRL_5)
    ) u_match_timer5 (
        .instr  (INSTR),
        .valid  (INSTR_VALID),
        .hit    (hit[alc_pkg::SRC_TIMER5])
    );

    // Control registers pass whole; the stack pointer is padded with a zero
    // on top so a stale high bit can never reach the accumulator
    always_comb
    begin
        src[alc_pkg::SRC_PULLUP3] = PULLUP_CTRL_REG_3;
        src[alc_pkg::SRC_STACK]   = {1'b0, STACK_POINTER};
        src[alc_pkg::SRC_IRQ1]    = IRQ_CTRL_FIRST;
        src[alc_pkg::SRC_IRQ2]    = IRQ_CTRL_SECOND;
        src[alc_pkg::SRC_TIMER1]  = TIMER_CTRL_FIRST;
        src[alc_pkg::SRC_TIMER2]  = TIMER_CTRL_SECOND;
        src[alc_pkg::SRC_TIMER3]  = TIMER_CTRL_THIRD;
        src[alc_pkg::SRC_TIMER4]  = TIMER_CTRL_FOURTH;
        src[alc_pkg::SRC_TIMER5]  = TIMER_CTRL_FIFTH;
    end

    // Opcodes are distinct, so at most one hit bit is ever set; an OR of
    // masked sources avoids a priority chain that would hide a decode slip.
    // Select and strobe move together so the core sees them on one edge
    always_comb
    begin
        sel_nxt = hit;
        we_nxt  = |hit;
    end

    always_ff @(posedge CLK)
    begin
        // Both clear in reset so no stray write follows its release
        if (RST)
        begin
            we_r  <= 1'b0;
            sel_r <= alc_pkg::SRC_SEL_RST;
        end
        else
        begin
            we_r  <= we_nxt;
            sel_r <= sel_nxt;
        end
    end

    // Data is a group of its own: it holds between writes, the strobe does not
    always_comb
    begin
        wdata_nxt = wdata_r;
        if (we_nxt)
        begin
            wdata_nxt = '0;
            for (int k = 0; k < alc_pkg::NUM_SRC; k++)
            begin
                wdata_nxt = wdata_nxt | (src[k] & {alc_pkg::DATA_W{hit[k]}});
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            wdata_r <= alc_pkg::ACC_WDATA_RST;
        end
        else
        begin
            wdata_r <= wdata_nxt;
        end
    end

    // Decode hit stays combinational for same-cycle use by the core
    assign DECODE_HIT    = |hit;
    assign ACC_WE        = we_r;
    assign ACC_WDATA     = wdata_r;
    assign SRC_SEL       = sel_r;
    // These loads never touch carry and never skip the next word
    assign CARRY_FLAG_WE = 1'b0;
    assign SKIP_REQ      = 1'b0;

endmodule : alc_acc_load

`default_nettype wire

// ---- rtl/alc_op_match.sv ----
/*
 * One opcode comparator: full-width compare of the instruction word.
 * Assumes the instruction word is stable while valid is high.
 */
`timescale 1ns/1ps
`default_nettype none

module alc_op_match #(
    parameter logic [alc_pkg::INSTR_W-1:0] OPCODE = 10'h000
) (
    input  wire logic [alc_pkg::INSTR_W-1:0] instr,
    input  wire logic                        valid,
    output logic                             hit
);

    // All ten bits compared, so no partial pattern can alias another
    assign hit = valid && (instr == OPCODE);

endmodule : alc_op_match

`default_nettype wire

// ---- rtl/alc_pkg.sv ----
/*
 * Constants for the accumulator-load decode slice: opcodes, source
 * indices, widths and reset values.
 * Assumes a 10-bit instruction word and 4-bit data path.
 */
package alc_pkg;

    localparam int INSTR_W   = 10;
    localparam int DATA_W    = 4;
    localparam int SP_W      = 3;
    localparam int NUM_SRC   = 9;

    // Source select indices, one bit each in the one-hot select
    localparam int SRC_PULLUP3 = 0;
    localparam int SRC_STACK   = 1;
    localparam int SRC_IRQ1    = 2;
    localparam int SRC_IRQ2    = 3;
    localparam int SRC_TIMER1  = 4;
    localparam int SRC_TIMER2  = 5;
    localparam int SRC_TIMER3  = 6;
    localparam int SRC_TIMER4  = 7;
    localparam int SRC_TIMER5  = 8;

    localparam logic [INSTR_W-1:0] OP_LOAD_ACC_PULLUP_CTRL_3  = 10'h25D;
    localparam logic [INSTR_W-1:0] OP_LOAD_ACC_STACK_POINTER  = 10'h050;
    localparam logic [INSTR_W-1:0] OP_LOAD_ACC_IRQ_CTRL_FIRST = 10'h054;
    localparam logic [INSTR_W-1:0] OP_LOAD_ACC_IRQ_CTRL_SECOND = 10'h055;
    localparam logic [INSTR_W-1:0] OP_LOAD_ACC_TIMER_CTRL_1   = 10'h24B;
    localparam logic [INSTR_W-1:0] OP_LOAD_ACC_TIMER_CTRL_2   = 10'h24C;
    localparam logic [INSTR_W-1:0] OP_LOAD_ACC_TIMER_CTRL_3   = 10'h24D;
    localparam logic [INSTR_W-1:0] OP_LOAD_ACC_TIMER_CTRL_4   = 10'h24E;
    localparam logic [INSTR_W-1:0] OP_LOAD_ACC_TIMER_CTRL_5   = 10'h24F;

    // Entry i holds the opcode for source index i
    localparam logic [NUM_SRC-1:0][INSTR_W-1:0] OPCODE_TABLE = {
        OP_LOAD_ACC_TIMER_CTRL_5,
        OP_LOAD_ACC_TIMER_CTRL_4,
        OP_LOAD_ACC_TIMER_CTRL_3,
        OP_LOAD_ACC_TIMER_CTRL_2,
        OP_LOAD_ACC_TIMER_CTRL_1,
        OP_LOAD_ACC_IRQ_CTRL_SECOND,
        OP_LOAD_ACC_IRQ_CTRL_FIRST,
        OP_LOAD_ACC_STACK_POINTER,
        OP_LOAD_ACC_PULLUP_CTRL_3
    };

    localparam logic [DATA_W-1:0]  ACC_WDATA_RST = 4'h0;
    localparam logic [NUM_SRC-1:0] SRC_SEL_RST   = 9'h000;

endpackage : alc_pkg

// ---- testbench/alc_acc_load_properties.sv ----
/* Checker for the accumulator-load slice: decode, write strobe, select and data.
   Assumes it is bound to alc_acc_load and sees only that module's ports. */
`timescale 1ns/1ps
`default_nettype none
module alc_acc_load_chk (
    input wire logic       CLK,
    input wire logic       RST,
    input wire logic       INSTR_VALID,
    input wire logic       DECODE_HIT,
    input wire logic       ACC_WE,
    input wire logic       CARRY_FLAG_WE,
    input wire logic       SKIP_REQ,
    input wire logic [9:0] INSTR,
    input wire logic [3:0] ACC_WDATA,
    input wire logic [3:0] TIMER_CTRL_FIRST,
    input wire logic [3:0] PULLUP_CTRL_REG_3,
    input wire logic [2:0] STACK_POINTER,
    input wire logic [8:0] SRC_SEL
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_take(op);
        DECODE_HIT && INSTR == op;
    endsequence
    we_after_hit_a: assert property (DECODE_HIT |=> ACC_WE) else $error("no write");
    sel_onehot_a: assert property (ACC_WE |-> $onehot(SRC_SEL)) else $error("sel");
    sel_idle_a: assert property (!ACC_WE |-> SRC_SEL == 9'h000) else $error("sel idle");
    carry_kept_a: assert property (CARRY_FLAG_WE == 1'b0) else $error("carry");
    skip_never_a: assert property (SKIP_REQ == 1'b0) else $error("skip");
    wdata_hold_a: assert property (!ACC_WE |-> $stable(ACC_WDATA)) else $error("hold");
    refuse_idle_a: assert property (!INSTR_VALID |-> !DECODE_HIT ##1 !ACC_WE)
        else $error("refuse");
    stack_load_a: assert property (s_take(alc_pkg::OP_LOAD_ACC_STACK_POINTER) |=>
        SRC_SEL[1] && ACC_WDATA == {1'b0, $past(STACK_POINTER)}) else $error("stack");
    timer_load_a: assert property (s_take(alc_pkg::OP_LOAD_ACC_TIMER_CTRL_1) |=>
        SRC_SEL[4] && ACC_WDATA == $past(TIMER_CTRL_FIRST)) else $error("timer");
    pullup_load_a: assert property (s_take(alc_pkg::OP_LOAD_ACC_PULLUP_CTRL_3) |=>
        SRC_SEL[0] && ACC_WDATA == $past(PULLUP_CTRL_REG_3)) else $error("pullup");
endmodule : alc_acc_load_chk
bind alc_acc_load alc_acc_load_chk alc_acc_load_chk_i (
    .CLK               (CLK),
    .RST               (RST),
    .INSTR_VALID       (INSTR_VALID),
    .DECODE_HIT        (DECODE_HIT),
    .ACC_WE            (ACC_WE),
    .CARRY_FLAG_WE     (CARRY_FLAG_WE),
    .SKIP_REQ          (SKIP_REQ),
    .INSTR             (INSTR),
    .ACC_WDATA         (ACC_WDATA),
    .TIMER_CTRL_FIRST  (TIMER_CTRL_FIRST),
    .PULLUP_CTRL_REG_3 (PULLUP_CTRL_REG_3),
    .STACK_POINTER     (STACK_POINTER),
    .SRC_SEL           (SRC_SEL)
);
`default_nettype wire

// ---- testbench/tb_top.sv ----
/* Self-checking bench for alc_acc_load: every load back to back, refusals, data hold.
   Assumes the package, the design and the checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic       CLK = 0, RST = 1, VAL = 0, HIT, WE, CWE, SKIP;
    logic [9:0] INS = 10'h000;
    logic [3:0] WD;
    logic [8:0] SEL;
    logic [3:0] src [9] = '{4'hF, 4'hE, 4'hD, 4'hC, 4'hB, 4'hA, 4'h9, 4'h8, 4'h7};
    int         fails = 0, cmp_count = 0, cyc = 0;
    always #25 CLK = ~CLK;
    alc_acc_load alc_acc_load_i (.CLK, .RST, .INSTR(INS), .INSTR_VALID(VAL),
        .PULLUP_CTRL_REG_3(src[0]), .STACK_POINTER(src[1][2:0]), .IRQ_CTRL_FIRST(src[2]),
        .IRQ_CTRL_SECOND(src[3]), .TIMER_CTRL_FIRST(src[4]), .TIMER_CTRL_SECOND(src[5]),
        .TIMER_CTRL_THIRD(src[6]), .TIMER_CTRL_FOURTH(src[7]), .TIMER_CTRL_FIFTH(src[8]),
        .DECODE_HIT(HIT), .ACC_WE(WE), .ACC_WDATA(WD), .SRC_SEL(SEL), .CARRY_FLAG_WE(CWE),
        .SKIP_REQ(SKIP));
    task results;
        if (fails == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    task chk(input logic [9:0] s, input logic [9:0] e);
        cmp_count++;
        if (s !== e)
        begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, s, e);
        end
    endtask : chk
    // Inputs move 2 ns after the edge; outputs are judged 1 ns later, once settled
    task drive(input logic v, input logic [9:0] op);
        @(posedge CLK);
        #2 VAL = v;
        INS = op;
        #1;
    endtask : drive
    // One opcode per cycle; each result is judged while the next is presented
    task t_all_loads;
        for (int i = 0; i < 10; i++)
        begin
            drive(i < 9, i < 9 ? alc_pkg::OPCODE_TABLE[i] : 10'h000);
            chk(HIT, i < 9);
            chk({CWE, SKIP}, 0);
            if (i > 0)
            begin
                chk(WE, 1);
                chk(WD, i == 2 ? {1'b0, src[1][2:0]} : src[i-1]);
                chk(SEL, 9'h001 << (i - 1));
            end
        end
    endtask : t_all_loads
    // Near-miss opcode and an idle slot must leave the last written data alone
    task t_refuse;
        drive(1, alc_pkg::OP_LOAD_ACC_TIMER_CTRL_1 ^ 10'h200);
        src[4] = 4'h3;
        chk(HIT, 0);
        drive(0, alc_pkg::OP_LOAD_ACC_TIMER_CTRL_1);
        chk({HIT, WE, WD}, {2'b00, 4'h7});
        drive(1, alc_pkg::OP_LOAD_ACC_TIMER_CTRL_1);
        chk({HIT, WE, WD}, {2'b10, 4'h7});
        drive(0, 10'h000);
        chk({WE, WD}, {1'b1, 4'h3});
        drive(0, 10'h000);
        chk({WE, SEL}, 0);
    endtask : t_refuse
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc == 500)
        begin
            fails++;
            results;
        end
    end
    initial
    begin
        repeat (3) @(posedge CLK);
        #2 RST = 0;
        #1;
        chk({WE, WD}, 0);
        chk(SEL, 0);
        t_all_loads;
        t_refuse;
        results;
    end
endmodule : tb_top
`default_nettype wire
